//--- design/ocfg_params.svh
// Purpose: constants of the command option configuration block
// Assumes: byte-wide option registers, 8-bit opcodes
// Notes: register addresses are local choices
`ifndef OCFG_PARAMS_SVH
`define OCFG_PARAMS_SVH

// opcodes seen on the command port
`define OCFG_OP_REG_READ 8'h65
`define OCFG_OP_REG_WRITE 8'h71
`define OCFG_OP_RESET_ENABLE 8'h66
`define OCFG_OP_RESET 8'h99
`define OCFG_OP_LEGACY_RESET 8'hF0

// register addresses on the generic register commands
`define OCFG_ADDR_BOOT 24'h000004
`define OCFG_ADDR_LIVE 24'h800004

// option bit positions
`define OCFG_BIT_BLANK_CHECK 5
`define OCFG_BIT_PAGE_WRAP 4
`define OCFG_BIT_SECTOR_MAP 3
`define OCFG_BIT_BLOCK_SIZE 1
`define OCFG_BIT_LEGACY_RST 0

// implemented bits, factory value, bits software may set in the live copy
`define OCFG_IMPL_MASK 8'h3B
`define OCFG_FACTORY 8'h02
`define OCFG_LIVE_WR_MASK 8'h33

// page buffer wrap points, last byte index
`define OCFG_PB_LAST_256 9'h0FF
`define OCFG_PB_LAST_512 9'h1FF

// parameter sector window size, log2 of bytes
`define OCFG_PARAM_WIN_LOG2 15

// erase kinds
`define OCFG_KIND_PARAM 2'h0
`define OCFG_KIND_SECTOR 2'h1
`define OCFG_KIND_BULK 2'h2

`endif

//--- design/ocfg_pkg.sv
// Purpose: types of the command option configuration block
// Assumes: constants come from ocfg_params.svh
// Notes: none
package ocfg_pkg;

  typedef enum logic [4:0] {
    OCFG_ER_IDLE = 5'h01,
    OCFG_ER_STATUS = 5'h02,
    OCFG_ER_BLANK = 5'h04,
    OCFG_ER_START = 5'h08,
    OCFG_ER_SKIP = 5'h10
  } ocfg_erase_e;

  typedef struct packed {
    logic blank_check;
    logic page_wrap_512;
    logic uniform_map;
    logic block_256k;
    logic legacy_reset_en;
  } ocfg_opts_s;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] wdata;
  } ocfg_cmd_s;

  typedef struct packed {
    logic [7:0] value;
    logic [7:0] burned;
    logic [15:0] busy_cnt;
  } ocfg_otp_s;

  typedef struct packed {
    logic [7:0] live;
    ocfg_erase_e est;
    logic [7:0] rdata;
    logic rvalid;
    logic reset_armed;
    logic soft_rst;
    logic boot_load;
    logic [1:0] hw_sync;
    logic hw_prev;
    logic [8:0] pb_addr;
    logic erase_go;
    logic erase_skip;
    logic in_param;
  } ocfg_state_s;

endpackage

//--- design/ocfg_otp_bits.sv
// Purpose: one-time programmable boot copy of the option bits
// Assumes: rst stands for power-on, restoring the factory image
// Notes: programming time is a count of cycles
`timescale 1ns/1ps
`default_nettype none
`include "ocfg_params.svh"

module ocfg_otp_bits
  import ocfg_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic prog_valid,
  input wire logic [7:0] prog_data,
  output logic [7:0] value,
  output logic busy
);

  ocfg_otp_s s_q;
  ocfg_otp_s s_d;
  logic [7:0] val_n;
  logic [7:0] burn_n;
  logic take;

  assign take = prog_valid && (s_q.busy_cnt == 16'h0000);

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      localparam logic DEF = 1'(`OCFG_FACTORY >> b);
      localparam logic IMPL = 1'(`OCFG_IMPL_MASK >> b);
      logic flip;
      assign flip = take && IMPL && !s_q.burned[b] && (prog_data[b] != DEF);
      assign val_n[b] = flip ? ~DEF : s_q.value[b];
      assign burn_n[b] = s_q.burned[b] | flip;
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    s_d.value = val_n;
    s_d.burned = burn_n;
    if (take) begin
      s_d.busy_cnt = 16'(PROG_CYCLES);
    end else if (s_q.busy_cnt != 16'h0000) begin
      s_d.busy_cnt = s_q.busy_cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{value: `OCFG_FACTORY, burned: 8'h00, busy_cnt: 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign value = s_q.value;
  assign busy = (s_q.busy_cnt != 16'h0000);

endmodule // ocfg_otp_bits
`default_nettype wire

//--- design/ocfg_cmd_options.sv
// Purpose: command option register pair with the logic it steers
// Assumes: command port and array engine share clk
// Notes: reset pin is asynchronous to clk and synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "ocfg_params.svh"

// Function
// - both copies read by register-read and written by register-write commands
// - power-on, hardware or software reset loads live copy from boot copy
// - each implemented boot bit may leave its factory value once, never return
// - bit 5 one enables blank check, zero disables it
// - blank check first looks at status; failed last erase means erase
// - good last erase: read sector, start erase at first zero bit
// - no zero bit found during blank read: skip the rest of erase
// - blank check covers parameter, sector and whole-array erase
// - blank check off: every erase starts at once, unconditionally
// - bit 4 picks page buffer wrap: one at 512, zero at 256
// - with 256 wrap, loads past byte 255 continue at address zero
// - bit 3 one gives uniform sectors, zero keeps 4 KB parameter sectors
// - parameter sectors overlay the top or bottom 32 KB of array
// - default map is hybrid with parameter sectors at bottom
// - bit 1 sets block erase area to 256 KB; ignored on largest part
// - bit 0 one makes F0h a software reset, zero ignores it
// - 66h then 99h always performs a software reset
module ocfg_cmd_options
  import ocfg_pkg::*;
#(
  parameter int unsigned ARRAY_ADDR_W = 26,
  parameter bit LARGEST_DENSITY = 1'b0,
  parameter int unsigned PROG_CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hw_reset_pin_n,
  input wire ocfg_cmd_s cmd,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic boot_busy,
  output logic soft_reset,
  output ocfg_opts_s opts,
  input wire logic pb_load_start,
  input wire logic [8:0] pb_start_addr,
  input wire logic pb_load_byte,
  output logic [8:0] pb_addr,
  input wire logic [ARRAY_ADDR_W-1:0] map_addr,
  input wire logic param_at_top,
  output logic in_param_sector,
  input wire logic erase_req,
  input wire logic [1:0] erase_kind,
  input wire logic status_valid,
  input wire logic last_erase_ok,
  output logic blank_read_active,
  input wire logic blank_word_valid,
  input wire logic blank_word_has_zero,
  input wire logic blank_read_last,
  output logic erase_go,
  output logic erase_skip,
  output logic erase_busy
);

  localparam logic [ARRAY_ADDR_W-1:0] WIN_MASK =
    ARRAY_ADDR_W'({`OCFG_PARAM_WIN_LOG2{1'b1}});

  ocfg_state_s s_q;
  ocfg_state_s s_d;
  logic [7:0] boot_val;
  logic boot_prog;
  logic hit_boot;
  logic hit_live;
  logic is_read;
  logic is_write;
  logic hw_reset_edge;
  logic reload;
  logic [8:0] pb_last;
  logic bc_on;
  logic bc_kind;
  logic [ARRAY_ADDR_W-1:0] win_base;

  ocfg_otp_bits #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_boot (
    .clk(clk),
    .rst(rst),
    .prog_valid(boot_prog),
    .prog_data(cmd.wdata),
    .value(boot_val),
    .busy(boot_busy)
  );

  assign is_read = cmd.valid && (cmd.opcode == `OCFG_OP_REG_READ);
  assign is_write = cmd.valid && (cmd.opcode == `OCFG_OP_REG_WRITE);
  assign hit_boot = (cmd.addr == `OCFG_ADDR_BOOT);
  assign hit_live = (cmd.addr == `OCFG_ADDR_LIVE);

  assign boot_prog = is_write && hit_boot && !reload;

  // only the second stage is looked at; reset acts on pin falling
  assign hw_reset_edge = s_q.hw_prev && !s_q.hw_sync[1];

  assign reload = s_q.boot_load || s_q.soft_rst || hw_reset_edge;

  assign pb_last = s_q.live[`OCFG_BIT_PAGE_WRAP] ? `OCFG_PB_LAST_512 : `OCFG_PB_LAST_256;

  assign bc_on = s_q.live[`OCFG_BIT_BLANK_CHECK];

  assign bc_kind = (erase_kind == `OCFG_KIND_PARAM) ||
                   (erase_kind == `OCFG_KIND_SECTOR) ||
                   (erase_kind == `OCFG_KIND_BULK);

  assign win_base = param_at_top ? ~WIN_MASK : '0;

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.soft_rst = 1'b0;
    s_d.boot_load = 1'b0;
    s_d.erase_go = 1'b0;
    s_d.erase_skip = 1'b0;
    s_d.hw_sync = {s_q.hw_sync[0], hw_reset_pin_n};
    s_d.hw_prev = s_q.hw_sync[1];

    if (is_read) begin
      s_d.rvalid = 1'b1;
      if (hit_boot) begin
        s_d.rdata = boot_val & `OCFG_IMPL_MASK;
      end else if (hit_live) begin
        s_d.rdata = s_q.live & `OCFG_IMPL_MASK;
      end else begin
        s_d.rdata = 8'h00;
      end
    end

    if (is_write && hit_live) begin
      s_d.live = (cmd.wdata & `OCFG_LIVE_WR_MASK) |
                 (s_q.live & ~`OCFG_LIVE_WR_MASK);
    end

    s_d.live[`OCFG_BIT_SECTOR_MAP] = boot_val[`OCFG_BIT_SECTOR_MAP];

    if (cmd.valid) begin
      s_d.reset_armed = (cmd.opcode == `OCFG_OP_RESET_ENABLE);
      if (cmd.opcode == `OCFG_OP_RESET && s_q.reset_armed) begin
        s_d.soft_rst = 1'b1;
      end
      if (cmd.opcode == `OCFG_OP_LEGACY_RESET && s_q.live[`OCFG_BIT_LEGACY_RST]) begin
        s_d.soft_rst = 1'b1;
      end
    end

    if (pb_load_start) begin
      s_d.pb_addr = pb_start_addr & pb_last;
    end else if (pb_load_byte) begin
      if (s_q.pb_addr == pb_last) begin
        s_d.pb_addr = 9'h000;
      end else begin
        s_d.pb_addr = (s_q.pb_addr + 9'h001) & pb_last;
      end
    end

    s_d.in_param = !s_q.live[`OCFG_BIT_SECTOR_MAP] &&
                   ((map_addr & ~WIN_MASK) == win_base);

    case (s_q.est)
      OCFG_ER_IDLE: begin
        if (erase_req) begin
          if (bc_on && bc_kind) begin
            s_d.est = OCFG_ER_STATUS;
          end else begin
            s_d.est = OCFG_ER_START;
          end
        end
      end
      OCFG_ER_STATUS: begin
        if (status_valid) begin
          if (last_erase_ok) begin
            s_d.est = OCFG_ER_BLANK;
          end else begin
            s_d.est = OCFG_ER_START;
          end
        end
      end
      OCFG_ER_BLANK: begin
        if (blank_word_valid) begin
          if (blank_word_has_zero) begin
            s_d.est = OCFG_ER_START;
          end else if (blank_read_last) begin
            s_d.est = OCFG_ER_SKIP;
          end
        end
      end
      OCFG_ER_START: begin
        s_d.erase_go = 1'b1;
        s_d.est = OCFG_ER_IDLE;
      end
      OCFG_ER_SKIP: begin
        s_d.erase_skip = 1'b1;
        s_d.est = OCFG_ER_IDLE;
      end
      default: begin
        s_d.est = OCFG_ER_IDLE;
      end
    endcase

    if (reload) begin
      s_d.live = boot_val & `OCFG_IMPL_MASK;
      s_d.est = OCFG_ER_IDLE;
      s_d.reset_armed = 1'b0;
      s_d.pb_addr = 9'h000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{
        live: `OCFG_FACTORY,
        est: OCFG_ER_IDLE,
        rdata: 8'h00,
        rvalid: 1'b0,
        reset_armed: 1'b0,
        soft_rst: 1'b0,
        boot_load: 1'b1,
        hw_sync: 2'b11,
        hw_prev: 1'b1,
        pb_addr: 9'h000,
        erase_go: 1'b0,
        erase_skip: 1'b0,
        in_param: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_valid = s_q.rvalid;
  assign rd_data = s_q.rdata;
  assign soft_reset = s_q.soft_rst;
  assign pb_addr = s_q.pb_addr;
  assign in_param_sector = s_q.in_param;
  assign erase_go = s_q.erase_go;
  assign erase_skip = s_q.erase_skip;
  assign blank_read_active = (s_q.est == OCFG_ER_BLANK);
  assign erase_busy = (s_q.est != OCFG_ER_IDLE);

  assign opts.blank_check = s_q.live[`OCFG_BIT_BLANK_CHECK];
  assign opts.page_wrap_512 = s_q.live[`OCFG_BIT_PAGE_WRAP];
  assign opts.uniform_map = s_q.live[`OCFG_BIT_SECTOR_MAP];
  assign opts.block_256k = LARGEST_DENSITY ? 1'b1 : s_q.live[`OCFG_BIT_BLOCK_SIZE];
  assign opts.legacy_reset_en = s_q.live[`OCFG_BIT_LEGACY_RST];

endmodule // ocfg_cmd_options
`default_nettype wire

//--- test/ocfg_host.sv
// Purpose: host model issuing register commands
// Assumes: commands launched 1 ns after the clock edge
// Notes: released command fields are inverted, never held
`timescale 1ns/1ps
`default_nettype none
module ocfg_host
  import ocfg_pkg::*;
(
  input wire logic clk,
  output ocfg_cmd_s cmd
);
  logic map_boot;
  initial begin
    cmd = '0;
    map_boot = 1'b0;
  end
  // one command held to next edge
  task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d);
    logic [7:0] w;
    w = d;
    if (op == 8'h71 && a == 24'h800004) w[3] = map_boot;
    if (op == 8'h71 && a == 24'h000004) map_boot = map_boot | d[3];
    @(posedge clk);
    #1;
    cmd = {1'b1, op, a, w};
  endtask
  task automatic idle();
    @(posedge clk);
    #1;
    cmd = {1'b0, ~cmd[39:0]};
  endtask
endmodule // ocfg_host
`default_nettype wire

//--- test/ocfg_cmd_options_asserts.sv
// Purpose: port checks of the option block
// Assumes: one clock, rst synchronous
// Notes: erase stream driven only while wanted
`timescale 1ns/1ps
`default_nettype none
module ocfg_chk
  import ocfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire ocfg_cmd_s cmd,
  input wire logic rd_valid,
  input wire logic soft_reset,
  input wire ocfg_opts_s opts,
  input wire logic pb_load_start,
  input wire logic pb_load_byte,
  input wire logic [8:0] pb_addr,
  input wire logic erase_req,
  input wire logic [1:0] erase_kind,
  input wire logic status_valid,
  input wire logic last_erase_ok,
  input wire logic blank_read_active,
  input wire logic blank_word_valid,
  input wire logic blank_word_has_zero,
  input wire logic blank_read_last,
  input wire logic erase_go,
  input wire logic erase_skip,
  input wire logic erase_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_arm;
    cmd.valid && cmd.opcode == 8'h66 ##1 cmd.valid && cmd.opcode == 8'h99;
  endsequence
  a_read_answer: assert property (cmd.valid && cmd.opcode == 8'h65 |=> rd_valid)
    else $error("read not answered");
  a_wrap_small: assert property (pb_load_byte && !pb_load_start && !opts.page_wrap_512
    |=> pb_addr == {1'b0, $past(pb_addr[7:0]) + 8'h01}) else $error("256 wrap wrong");
  a_wrap_large: assert property (pb_load_byte && !pb_load_start && opts.page_wrap_512
    |=> pb_addr == $past(pb_addr) + 9'h001) else $error("512 wrap wrong");
  a_direct_go: assert property (erase_req && !erase_busy && (!opts.blank_check || erase_kind == 2'h3)
    |-> ##2 erase_go) else $error("erase not started");
  a_fail_go: assert property (erase_busy && !blank_read_active && status_valid && !last_erase_ok
    && opts.blank_check |-> ##2 erase_go) else $error("failed sector not erased");
  a_zero_go: assert property (blank_read_active && blank_word_valid && blank_word_has_zero
    |-> ##2 erase_go) else $error("zero bit did not start erase");
  a_blank_skip: assert property (blank_read_active && blank_word_valid && blank_read_last
    && !blank_word_has_zero |-> ##2 erase_skip) else $error("blank sector not skipped");
  a_arm_reset: assert property (s_arm |=> soft_reset)
    else $error("armed reset missing");
  a_legacy_reset: assert property (cmd.valid && cmd.opcode == 8'hF0
    |=> soft_reset == $past(opts.legacy_reset_en)) else $error("legacy reset wrong");
endmodule // ocfg_chk
`default_nettype wire

//--- test/ocfg_cmd_options_tb_top.sv
// Purpose: self-checking bench of the option block
// Assumes: host model sends commands, bench plays the array engine
// Notes: short boot programming time keeps the run brief
`timescale 1ns/1ps
`default_nettype none
module ocfg_cmd_options_tb_top
  import ocfg_pkg::*;
;
  logic clk, rst, hw_reset_pin_n, pb_load_start, pb_load_byte, param_at_top, erase_req, status_valid;
  logic last_erase_ok, blank_word_valid, blank_word_has_zero, blank_read_last, rd_valid, boot_busy;
  logic soft_reset, in_param_sector, blank_read_active, erase_go, erase_skip, erase_busy;
  logic [7:0] rd_data, boot, wd;
  logic [8:0] pb_start_addr, pb_addr, e;
  logic [25:0] map_addr;
  logic [1:0] erase_kind;
  ocfg_cmd_s cmd;
  ocfg_opts_s opts;
  int fail_count, checks, seed, i;
  ocfg_cmd_options #(.PROG_CYCLES(2)) dut_u (.clk, .rst, .hw_reset_pin_n, .cmd, .rd_valid, .rd_data,
    .boot_busy, .soft_reset, .opts, .pb_load_start, .pb_start_addr, .pb_load_byte, .pb_addr, .map_addr,
    .param_at_top, .in_param_sector, .erase_req, .erase_kind, .status_valid, .last_erase_ok,
    .blank_read_active, .blank_word_valid, .blank_word_has_zero, .blank_read_last, .erase_go,
    .erase_skip, .erase_busy);
  ocfg_host host_u (.clk, .cmd);
  always #50 clk = ~clk;
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [8:0] x, input logic [8:0] g);
    checks++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", s, x, g);
    end
  endtask
  function automatic logic [7:0] otp(input logic [7:0] b, input logic [7:0] d);
    return 8'h02 ^ ((b ^ 8'h02) | ((d ^ 8'h02) & 8'h3B));
  endfunction
  function automatic logic [8:0] opv(input logic [7:0] v);
    return {4'h0, v[5], v[4], v[3], v[1], v[0]};
  endfunction
  task automatic cmd1(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d);
    host_u.send(op, a, d);
    host_u.idle();
  endtask
  task automatic rd(input string s, input logic [23:0] a, input logic [7:0] x);
    cmd1(8'h65, a, 8'h00);
    chk(s, {1'b1, x}, {rd_valid, rd_data});
  endtask
  task automatic sr(input string s, input logic [7:0] op, input logic x);
    cmd1(op, 24'h0, 8'h00);
    chk(s, {8'h00, x}, {8'h00, soft_reset});
  endtask
  task automatic wboot(input logic [7:0] d);
    int j;
    cmd1(8'h71, 24'h000004, d);
    for (j = 0; j < 20 && boot_busy !== 1'b0; j++) tick(1);
    chk("boot busy", 9'h000, {8'h00, boot_busy});
    if (j == 20) summarize();
    boot = otp(boot, d);
  endtask
  task automatic ers(input logic [1:0] k, input logic ok, input logic z, input logic sk);
    int j;
    erase_kind = k;
    erase_req = 1'b1;
    tick(1);
    erase_req = 1'b0;
    status_valid = 1'b1;
    last_erase_ok = ok;
    tick(1);
    status_valid = 1'b0;
    {blank_word_valid, blank_word_has_zero, blank_read_last} = {1'b1, z, 1'b1};
    for (j = 0; j < 10 && erase_go !== 1'b1 && erase_skip !== 1'b1; j++) tick(1);
    chk("erase end", {7'h00, sk, !sk}, {7'h00, erase_skip, erase_go});
    if (j == 10) summarize();
    blank_word_valid = 1'b0;
    tick(1);
  endtask
  initial begin
    {clk, rst, hw_reset_pin_n, boot, seed, fail_count, checks} = {3'b011, 8'h02, 32'd37154, 64'd0};
    {pb_load_start, pb_load_byte, pb_start_addr, map_addr, param_at_top, erase_req, erase_kind} = '0;
    {status_valid, last_erase_ok, blank_word_valid, blank_word_has_zero, blank_read_last} = '0;
    tick(20);
    rst = 1'b0;
    tick(2);
    rd("boot reset", 24'h000004, 8'h02);
    rd("live reset", 24'h800004, 8'h02);
    rd("unmapped", 24'h000010, 8'h00);
    chk("opts reset", opv(8'h02), {4'h0, opts});
    for (i = 0; i < 3; i++) begin
      param_at_top = i[1];
      map_addr = i[0] ? 26'h0008000 : (i[1] ? 26'h3FFFFFF : 26'h0);
      tick(1);
      chk("param window", {8'h00, !i[0]}, {8'h00, in_param_sector});
    end
    // map chosen before any array operation
    wboot(8'h20);
    wboot(8'h02);
    wboot(8'hC8);
    rd("boot burned", 24'h000004, boot);
    host_u.send(8'h66, 24'h0, 8'h00);
    sr("armed reset", 8'h99, 1'b1);
    tick(2);
    chk("opts reload", opv(boot), {4'h0, opts});
    chk("uniform map", 9'h000, {8'h00, in_param_sector});
    for (i = 0; i < 8; i++) begin
      wd = 8'($random(seed));
      cmd1(8'h71, 24'h800004, wd);
      chk("opts live", opv((wd & 8'h33) | (boot & 8'h08)), {4'h0, opts});
      rd("live", 24'h800004, (wd & 8'h33) | (boot & 8'h08));
    end
    for (i = 0; i < 8; i++) begin
      cmd1(8'h71, 24'h800004, {3'h0, i[1], 4'h0});
      pb_start_addr = i < 4 ? (i[0] ? 9'h1FF : 9'h0FF) : 9'($random(seed));
      e = i[1] ? pb_start_addr : {1'b0, pb_start_addr[7:0]};
      pb_load_start = 1'b1;
      tick(1);
      {pb_load_start, pb_load_byte} = 2'b01;
      chk("pb start", e, pb_addr);
      e = i[1] ? e + 9'h001 : {1'b0, e[7:0] + 8'h01};
      tick(1);
      pb_load_byte = 1'b0;
      chk("pb byte", e, pb_addr);
    end
    cmd1(8'h71, 24'h800004, 8'h00);
    ers(2'h0, 1'b1, 1'b0, 1'b0);
    cmd1(8'h71, 24'h800004, 8'h20);
    for (i = 0; i < 9; i++) ers(2'(i / 3), i % 3 != 0, i % 3 == 1, i % 3 == 2);
    ers(2'h3, 1'b1, 1'b0, 1'b0);
    cmd1(8'h71, 24'h800004, 8'h01);
    sr("legacy on", 8'hF0, 1'b1);
    tick(2);
    chk("opts soft", opv(boot), {4'h0, opts});
    sr("legacy off", 8'hF0, 1'b0);
    sr("lone reset", 8'h99, 1'b0);
    cmd1(8'h71, 24'h800004, 8'h00);
    hw_reset_pin_n = 1'b0;
    tick(4);
    hw_reset_pin_n = 1'b1;
    tick(3);
    chk("pin reload", opv(boot), {4'h0, opts});
    summarize();
  end
endmodule // ocfg_cmd_options_tb_top
bind ocfg_cmd_options ocfg_chk chk_u (.clk, .rst, .cmd, .rd_valid, .soft_reset, .opts, .pb_load_start,
  .pb_load_byte, .pb_addr, .erase_req, .erase_kind, .status_valid, .last_erase_ok, .blank_read_active,
  .blank_word_valid, .blank_word_has_zero, .blank_read_last, .erase_go, .erase_skip, .erase_busy);
`default_nettype wire
